/* asn_pkg.sv */
// package of constants and types for the accelerator shift and normalize control
package asn_pkg;

	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [7:0] ADDR_SHIFT_CONTROL = 8'hD1;
	localparam logic [7:0] RESET_SHIFT_CONTROL = 8'h00;

	// ********************************************************
	// control register field positions
	// ********************************************************
	localparam int POS_DIRECTION = 7;
	localparam int POS_CIRCULAR = 6;
	localparam int POS_CARRY_EN = 5;
	localparam int POS_COUNT_HI = 4;
	localparam int POS_COUNT_LO = 0;
	localparam int COUNT_WIDTH = 5;

	// ********************************************************
	// reset and special values
	// ********************************************************
	localparam logic RESET_CARRY_BIT = 1'h0;
	localparam logic [4:0] COUNT_NORMALIZE = 5'h00;
	localparam logic [4:0] NORM_LIMIT = 5'h1F;
	localparam logic DIR_TOWARD_MSB = 1'h0;
	localparam int VALUE_WIDTH = 32;

	// ********************************************************
	// sequencer states
	// ********************************************************
	typedef enum logic [1:0] {
		ASN_IDLE = 2'b00,
		ASN_SHIFT = 2'b01,
		ASN_NORM = 2'b10,
		ASN_DONE = 2'b11
	} asn_state_t;

endpackage

/* asn_shift_normalize.sv */
// shift and normalize control for the arithmetic accelerator
// Behaviour
// - direction bit 0 shifts toward the msb, 1 shifts toward the lsb
// - direction bit affects shift operations only, nothing else
// - direction bit clears on system reset and on accelerator init
// - circular mode without carry mode wraps the outgoing end bit into the other end
// - without circular or carry mode the vacated end bit is filled with zero
// - circular and carry enable bits clear on system reset
// - carry mode shifts the carry into lsb on left, msb on right
// - without carry mode the carry is never an input to the value
// - without circular mode the carry bit stays unchanged during shifts
// - circular plus carry mode loads carry from bit 31 left, bit 0 right
// - the five-bit count gives 1 to 31 shift positions
// - a zero count at load normalizes the loaded value instead
// - after normalization the count field holds the shifts performed
// - count field clears on system reset and on accelerator init
// - shift carry bit survives init and op start; changed only by write, reset or circular-plus-carry shifts
// - shift and normalize results go to the first operand register
`timescale 1ns/1ps
`default_nettype none

module asn_shift_normalize #(
	parameter int WIDTH = 32
) (
	input wire logic clk_in,
	input wire logic reset_in,
	// special function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic sfr_hit_out,
	// shift carry bit held in the neighbouring control register
	input wire logic carry_wr_in,
	input wire logic carry_wdata_in,
	output logic shift_carry_bit_out,
	// accelerator sequencing
	input wire logic accel_init_in,
	input wire logic op_start_in,
	input wire logic [WIDTH-1:0] operand_in,
	output logic [WIDTH-1:0] accel_operand_a_out,
	output logic busy_out,
	output logic done_out
);

	// ********************************************************
	// one-position shift step
	// ********************************************************
	// returns {new carry, new value} for one position
	function automatic logic [WIDTH:0] shift_step(
		input logic [WIDTH-1:0] value,
		input logic carry,
		input logic dir,
		input logic circ,
		input logic carry_en
	);
		logic fill;
		logic out_bit;
		logic next_c;
		logic [WIDTH-1:0] moved;
		out_bit = (dir == asn_pkg::DIR_TOWARD_MSB) ? value[WIDTH-1] : value[0];
		if (carry_en) begin
			fill = carry;
		end else if (circ) begin
			fill = out_bit;
		end else begin
			fill = 1'b0;
		end
		if (carry_en && circ) begin
			next_c = out_bit;
		end else begin
			next_c = carry;
		end
		if (dir == asn_pkg::DIR_TOWARD_MSB) begin
			moved = {value[WIDTH-2:0], fill};
		end else begin
			moved = {fill, value[WIDTH-1:1]};
		end
		shift_step = {next_c, moved};
	endfunction

	// ********************************************************
	// normalize stop test
	// ********************************************************
	// shared by the count update and the sequencer so both agree on the last step
	function automatic logic norm_finished(
		input logic [WIDTH-1:0] v,
		input logic [4:0] count
	);
		norm_finished = v[WIDTH-1] || (v == '0) || (count == asn_pkg::NORM_LIMIT);
	endfunction

	// ********************************************************
	// state
	// ********************************************************
	logic direction_sel;
	logic circular_shift_en;
	logic carry_shift_en;
	logic [4:0] shift_count;
	logic shift_carry_bit;
	logic [WIDTH-1:0] value;
	logic [4:0] steps_left;
	logic [4:0] norm_count;
	asn_pkg::asn_state_t state;
	logic [7:0] rdata;
	logic done;

	logic next_direction_sel;
	logic next_circular_shift_en;
	logic next_carry_shift_en;
	logic [4:0] next_shift_count;
	logic next_shift_carry_bit;
	logic [WIDTH-1:0] next_value;
	logic [4:0] next_steps_left;
	logic [4:0] next_norm_count;
	asn_pkg::asn_state_t next_state;
	logic [7:0] next_rdata;
	logic next_done;

	logic ctl_write;
	logic [WIDTH:0] stepped;
	logic [7:0] ctl_image;

	assign ctl_write = sfr_wr_in && (sfr_addr_in == asn_pkg::ADDR_SHIFT_CONTROL);
	assign stepped = shift_step(value, shift_carry_bit, direction_sel,
		circular_shift_en, carry_shift_en);

	// control register as software sees it
	always_comb begin
		ctl_image = 8'h00;
		ctl_image[asn_pkg::POS_DIRECTION] = direction_sel;
		ctl_image[asn_pkg::POS_CIRCULAR] = circular_shift_en;
		ctl_image[asn_pkg::POS_CARRY_EN] = carry_shift_en;
		ctl_image[asn_pkg::POS_COUNT_HI:asn_pkg::POS_COUNT_LO] = shift_count;
	end

	// ********************************************************
	// control register next values
	// ********************************************************
	// hardware count update wins over a software write in the same cycle
	always_comb begin
		next_direction_sel = direction_sel;
		next_circular_shift_en = circular_shift_en;
		next_carry_shift_en = carry_shift_en;
		next_shift_count = shift_count;
		if (ctl_write) begin
			next_direction_sel = sfr_wdata_in[asn_pkg::POS_DIRECTION];
			next_circular_shift_en = sfr_wdata_in[asn_pkg::POS_CIRCULAR];
			next_carry_shift_en = sfr_wdata_in[asn_pkg::POS_CARRY_EN];
			next_shift_count = sfr_wdata_in[asn_pkg::POS_COUNT_HI:asn_pkg::POS_COUNT_LO];
		end
		if (state == asn_pkg::ASN_NORM && norm_finished(value, norm_count)) begin
			next_shift_count = norm_count;
		end
		if (accel_init_in) begin
			next_direction_sel = 1'b0;
			next_shift_count = asn_pkg::COUNT_NORMALIZE;
		end
	end

	// control register flops
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			direction_sel <= asn_pkg::RESET_SHIFT_CONTROL[asn_pkg::POS_DIRECTION];
			circular_shift_en <= asn_pkg::RESET_SHIFT_CONTROL[asn_pkg::POS_CIRCULAR];
			carry_shift_en <= asn_pkg::RESET_SHIFT_CONTROL[asn_pkg::POS_CARRY_EN];
			shift_count <= asn_pkg::COUNT_NORMALIZE;
		end else begin
			direction_sel <= next_direction_sel;
			circular_shift_en <= next_circular_shift_en;
			carry_shift_en <= next_carry_shift_en;
			shift_count <= next_shift_count;
		end
	end

	// ********************************************************
	// shift carry bit
	// ********************************************************
	// not touched by init or by starting an operation, only by write, reset or circular-plus-carry shift steps
	always_comb begin
		next_shift_carry_bit = shift_carry_bit;
		if (carry_wr_in) begin
			next_shift_carry_bit = carry_wdata_in;
		end
		if (state == asn_pkg::ASN_SHIFT && !accel_init_in) begin
			next_shift_carry_bit = stepped[WIDTH];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			shift_carry_bit <= asn_pkg::RESET_CARRY_BIT;
		end else begin
			shift_carry_bit <= next_shift_carry_bit;
		end
	end

	// ********************************************************
	// operation sequencer
	// ********************************************************
	// one position per clock keeps the datapath small; 31 shifts take 31 cycles
	always_comb begin
		next_state = state;
		next_value = value;
		next_steps_left = steps_left;
		next_norm_count = norm_count;
		next_done = 1'b0;
		case (state)
			asn_pkg::ASN_IDLE, asn_pkg::ASN_DONE: begin
				next_state = asn_pkg::ASN_IDLE;
				if (op_start_in) begin
					next_value = operand_in;
					next_norm_count = 5'h00;
					next_steps_left = shift_count;
					if (shift_count == asn_pkg::COUNT_NORMALIZE) begin
						next_state = asn_pkg::ASN_NORM;
					end else begin
						next_state = asn_pkg::ASN_SHIFT;
					end
				end
			end
			asn_pkg::ASN_SHIFT: begin
				next_value = stepped[WIDTH-1:0];
				next_steps_left = steps_left - 5'h01;
				if (steps_left == 5'h01) begin
					next_state = asn_pkg::ASN_DONE;
					next_done = 1'b1;
				end
			end
			asn_pkg::ASN_NORM: begin
				// stop at msb set, all zero, or the count field limit
				if (norm_finished(value, norm_count)) begin
					next_state = asn_pkg::ASN_DONE;
					next_done = 1'b1;
				end else begin
					next_value = {value[WIDTH-2:0], 1'b0};
					next_norm_count = norm_count + 5'h01;
				end
			end
			default: begin
				next_state = asn_pkg::ASN_IDLE;
			end
		endcase
		// init abandons any operation in flight
		if (accel_init_in) begin
			next_state = asn_pkg::ASN_IDLE;
			next_value = '0;
			next_done = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= asn_pkg::ASN_IDLE;
			value <= '0;
			steps_left <= 5'h00;
			norm_count <= 5'h00;
			done <= 1'b0;
		end else begin
			state <= next_state;
			value <= next_value;
			steps_left <= next_steps_left;
			norm_count <= next_norm_count;
			done <= next_done;
		end
	end

	// ********************************************************
	// register read port
	// ********************************************************
	// read data is registered: valid the cycle after the read strobe
	always_comb begin
		next_rdata = 8'h00;
		if (sfr_rd_in && sfr_addr_in == asn_pkg::ADDR_SHIFT_CONTROL) begin
			next_rdata = ctl_image;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ********************************************************
	// outputs
	// ********************************************************
	// the direction bit reaches only the shift step, so other results ignore it
	assign sfr_rdata_out = rdata;
	assign sfr_hit_out = (sfr_addr_in == asn_pkg::ADDR_SHIFT_CONTROL);
	assign shift_carry_bit_out = shift_carry_bit;
	assign accel_operand_a_out = value;
	assign busy_out = (state == asn_pkg::ASN_SHIFT) || (state == asn_pkg::ASN_NORM);
	assign done_out = done;

endmodule

`default_nettype wire

/* asn_monitor.sv */
// concurrent checks on the shift and normalize control ports
`timescale 1ns/1ps
`default_nettype none
module asn_monitor #(
	parameter int WIDTH = 32
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic sfr_hit_out,
	input wire logic carry_wr_in,
	input wire logic carry_wdata_in,
	input wire logic shift_carry_bit_out,
	input wire logic accel_init_in,
	input wire logic op_start_in,
	input wire logic [WIDTH-1:0] accel_operand_a_out,
	input wire logic busy_out,
	input wire logic done_out
);
	// ************************************
	// port relations
	// ************************************
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// init aborts the operation and empties the value
	a_init_clears: assert property (accel_init_in && !op_start_in |=>
		accel_operand_a_out == '0 && !busy_out && !done_out) else $error("init left state");
	a_carry_hold: assert property (!carry_wr_in && !busy_out |=>
		$stable(shift_carry_bit_out)) else $error("carry bit moved");
	a_carry_load: assert property (carry_wr_in && !busy_out |=>
		shift_carry_bit_out == $past(carry_wdata_in)) else $error("carry write lost");
	a_start_taken: assert property (op_start_in && !busy_out && !accel_init_in |=>
		busy_out || done_out) else $error("start not taken");
	// one position a cycle, so 31 steps plus load is the worst case
	a_busy_bounded: assert property ($rose(busy_out) |-> ##[1:33] !busy_out)
		else $error("operation overran");
	a_done_idle: assert property (done_out |-> !busy_out)
		else $error("done while busy");
	a_value_holds: assert property (!busy_out && !op_start_in && !accel_init_in |=>
		$stable(accel_operand_a_out)) else $error("idle value moved");
	a_read_miss: assert property (sfr_rd_in && !sfr_hit_out |=>
		sfr_rdata_out == 8'h00)
		else $error("stray read data");
	c_done: cover property (done_out);
	c_abort: cover property (accel_init_in && busy_out);
	c_start: cover property (op_start_in && !busy_out);
endmodule
`default_nettype wire

/* accel_shift_normalize_control_bench.sv */
// self-checking bench for the shift and normalize control
`timescale 1ns/1ps
`default_nettype none
module accel_shift_normalize_control_bench;
	localparam logic [7:0] AD = asn_pkg::ADDR_SHIFT_CONTROL;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cwr = 1'b0;
	logic cwd = 1'b0;
	logic init = 1'b0;
	logic start = 1'b0;
	logic [31:0] opnd = 32'h00000000;
	logic [7:0] rdata;
	logic [7:0] r;
	logic [31:0] res;
	logic carry;
	logic busy;
	logic done;
	logic hit;
	int failures = 0;
	int num_checks = 0;
	// ************************************
	// clock, design and helpers
	// ************************************
	always #20 clk_in = ~clk_in;
	asn_shift_normalize DUT (.clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(addr),
		.sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
		.sfr_hit_out(hit), .carry_wr_in(cwr), .carry_wdata_in(cwd),
		.shift_carry_bit_out(carry), .accel_init_in(init), .op_start_in(start),
		.operand_in(opnd), .accel_operand_a_out(res), .busy_out(busy), .done_out(done));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// strobes drop one edge early so no task raises them in the same step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk_in) #1;
		wr = 1'b0;
		@(posedge clk_in) #1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		addr = a;
		rd = 1'b1;
		@(posedge clk_in) #1;
		rd = 1'b0;
		r = rdata;
		chk("hit", a == AD, hit);
		@(posedge clk_in) #1;
	endtask
	function automatic int lead(input logic [31:0] v);
		lead = 0;
		while (v != 0 && !v[31]) begin
			v = v << 1;
			lead++;
		end
	endfunction
	// reference: carry in bit 32, one position per step
	function automatic logic [32:0] model(input logic [7:0] k, input logic [31:0] v,
		input logic c);
		logic e;
		if (k[4:0] == 5'h00) return {c, v << lead(v)};
		for (int i = 0; i < k[4:0]; i++) begin
			e = k[5] ? c : (k[6] & (k[7] ? v[0] : v[31]));
			if (k[6] & k[5]) c = k[7] ? v[0] : v[31];
			v = k[7] ? {e, v[31:1]} : {v[30:0], e};
		end
		return {c, v};
	endfunction
	task automatic run(input logic [7:0] k, input logic [31:0] v, input logic c);
		logic [32:0] exp;
		int n;
		exp = model(k, v, c);
		cwd = c;
		cwr = 1'b1;
		@(posedge clk_in) #1;
		cwr = 1'b0;
		wr_reg(AD, k);
		opnd = v;
		start = 1'b1;
		@(posedge clk_in) #1;
		start = 1'b0;
		opnd = ~v;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk_in) #1;
			n++;
		end
		chk("done", 1, done);
		chk("value", exp[31:0], res);
		chk("carry", exp[32], carry);
		rd_reg(AD);
		chk("count", k[4:0] == 5'h00 ? {k[7:5], 5'(lead(v))} : k, r);
	endtask
	// ************************************
	// tests
	// ************************************
	initial begin
		void'($urandom(12));
		repeat (6) @(posedge clk_in);
		#1 reset_in = 1'b0;
		rd_reg(AD);
		chk("reset ctrl", asn_pkg::RESET_SHIFT_CONTROL, r);
		chk("reset carry", 0, carry);
		wr_reg(8'hD0, 8'hFF);
		rd_reg(8'hD0);
		chk("stray read", 0, r);
		rd_reg(AD);
		chk("stray write", 0, r);
		$display("test reset done");
		run(8'h00, 32'h00000000, 1'b1);
		run(8'h00, 32'h00000001, 1'b0);
		run(8'hE0, 32'h80000000, 1'b1);
		run(8'h1F, 32'hFFFFFFFF, 1'b1);
		run(8'hFF, 32'h12345678, 1'b0);
		for (int m = 0; m < 8; m++) run({3'(m), 5'h02}, 32'h80000001, 1'b1);
		$display("test corners done");
		repeat (40) run(8'($urandom), $urandom, 1'($urandom));
		$display("test random done");
		wr_reg(AD, 8'hFF);
		start = 1'b1;
		@(posedge clk_in) #1;
		start = 1'b0;
		repeat (3) @(posedge clk_in) #1;
		init = 1'b1;
		@(posedge clk_in) #1;
		init = 1'b0;
		chk("abort value", 0, res);
		chk("abort done", 0, done);
		rd_reg(AD);
		chk("abort ctrl", 8'h60, r);
		$display("test init done");
		// enables are still set here, so this reset really has to clear them
		reset_in = 1'b1;
		repeat (2) @(posedge clk_in) #1;
		reset_in = 1'b0;
		rd_reg(AD);
		chk("reset again ctrl", asn_pkg::RESET_SHIFT_CONTROL, r);
		chk("reset again carry", 0, carry);
		$display("test second reset done");
		close_out();
	end
	initial begin
		#(40 * 10000);
		failures++;
		close_out();
	end
endmodule
bind asn_shift_normalize asn_monitor #(.WIDTH(WIDTH)) u_mon (.clk_in(clk_in),
	.reset_in(reset_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
	.sfr_hit_out(sfr_hit_out), .carry_wr_in(carry_wr_in), .carry_wdata_in(carry_wdata_in),
	.shift_carry_bit_out(shift_carry_bit_out), .accel_init_in(accel_init_in),
	.op_start_in(op_start_in), .accel_operand_a_out(accel_operand_a_out),
	.busy_out(busy_out), .done_out(done_out));
`default_nettype wire
